// >>> rtl/cbr_pkg.sv
package cbr_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RESET = 6'h00;
  localparam logic [5:0] IDX_BIAS = 6'h04;
  localparam logic [5:0] IDX_MIDRAIL = 6'h05;
  localparam logic [5:0] IDX_MIC = 6'h06;
  localparam int IDX_W = 6;
  localparam int REG_W = 16;

  localparam logic [31:0] ADDR_RESET = {24'h0, IDX_RESET, 2'h0};
  localparam logic [31:0] ADDR_BIAS = {24'h0, IDX_BIAS, 2'h0};
  localparam logic [31:0] ADDR_MIDRAIL = {24'h0, IDX_MIDRAIL, 2'h0};
  localparam logic [31:0] ADDR_MIC = {24'h0, IDX_MIC, 2'h0};

  // field positions
  localparam int BIAS_SEL_LSB = 2;
  localparam int BIAS_ON_BIT = 0;
  localparam int MID_BUF_BIT = 6;
  localparam int MID_DIV_LSB = 1;
  localparam int MID_ON_BIT = 0;
  localparam int MIC_THR_LSB = 4;
  localparam int MIC_SHORT_LSB = 2;
  localparam int MIC_DET_BIT = 1;
  localparam int MIC_ON_BIT = 0;

  localparam logic [1:0] BIAS_LOW_POWER = 2'h0;
  localparam logic [1:0] BIAS_HIGH_PERF = 2'h2;
  localparam logic [1:0] MID_DIV_OFF = 2'h0;

  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef struct packed {
    logic [1:0] bias_level_select;
    logic bias_generator_on;
    logic midrail_buffer_on;
    logic [1:0] midrail_divider_select;
    logic midrail_output_on;
    logic [2:0] mic_current_threshold;
    logic [1:0] mic_short_threshold;
    logic mic_detect_on;
    logic mic_supply_on;
  } cbr_ctrl_type;

  localparam cbr_ctrl_type CTRL_DEFAULT = '{
    bias_level_select: BIAS_HIGH_PERF,
    bias_generator_on: 1'h0,
    midrail_buffer_on: 1'h0,
    midrail_divider_select: MID_DIV_OFF,
    midrail_output_on: 1'h0,
    mic_current_threshold: 3'h0,
    mic_short_threshold: 2'h0,
    mic_detect_on: 1'h0,
    mic_supply_on: 1'h0
  };

  // write strobe, valid in the data phase alongside hwdata
  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] idx;
  } cbr_wr_type;

  function automatic logic cbr_is_mapped(logic [IDX_W-1:0] idx);
    return (idx == IDX_RESET) || (idx == IDX_BIAS) ||
           (idx == IDX_MIDRAIL) || (idx == IDX_MIC);
  endfunction

endpackage

// >>> rtl/cbr_ahb_slave.sv
`timescale 1ns/1ns
`default_nettype none
module cbr_ahb_slave
  import cbr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] rd_data,
  output logic [IDX_W-1:0] rd_idx,
  output logic rd_take,
  output var cbr_wr_type wr,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  logic take;
  logic addr_ok;
  cbr_wr_type wr_ff;
  cbr_wr_type nxt_wr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;

  assign take = hsel && htrans[1] && hready;
  // only aligned word accesses in the low page are decoded
  assign addr_ok = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'h0) &&
                   (hsize == HSIZE_WORD);
  assign rd_idx = haddr[7:2];
  assign rd_take = take && !hwrite;

  // read data is sampled in the address phase from the next-state view,
  // so a write in the preceding data phase is already visible
  always_comb begin
    nxt_wr.en = take && hwrite && addr_ok && cbr_is_mapped(rd_idx);
    nxt_wr.idx = rd_idx;
    nxt_hrdata = hrdata_ff;
    if (rd_take) begin
      nxt_hrdata = addr_ok ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= '0;
      hrdata_ff <= 32'h0;
    end else begin
      wr_ff <= nxt_wr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign wr = wr_ff;
  assign hrdata = hrdata_ff;
  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'h1;
  assign hresp = HRESP_OKAY;

endmodule
`default_nettype wire

// >>> rtl/cbr_regs.sv
// Functional notes
// - any aligned word-size write to the reset/ident word restores every register default
// - reading the reset/ident word returns the fixed sixteen-bit device code
// - bias level select bits 3:2, default 10; 00 low power, 10 high perf
// - bias register bit 0 turns the bias generator on, reset off
// - midrail register bit 6 turns the midrail buffer on, reset off
// - midrail divider select bits 2:1, reset 00; off, normal, standby, fast
// - mic current threshold bits 6:4, reset 000, eight ascending levels
// - mic short threshold bits 3:2, reset 00, four ascending levels
// - mic register bit 1 enables current and short detection, reset off
// - mic register bit 0 enables the mic supply output, reset off
`timescale 1ns/1ns
`default_nettype none
module cbr_regs
  import cbr_pkg::*;
#(
  // arbitrary identification value
  parameter logic [REG_W-1:0] DEV_ID = 16'hC0DE
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output var cbr_ctrl_type ctrl
);

  cbr_wr_type wr;
  logic [IDX_W-1:0] rd_idx;
  logic rd_take;
  logic [31:0] rd_data;
  cbr_ctrl_type ctrl_ff;
  cbr_ctrl_type nxt_ctrl;

  cbr_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .rd_data(rd_data),
    .rd_idx(rd_idx),
    .rd_take(rd_take),
    .wr(wr),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr.en) begin
      case (wr.idx)
        IDX_RESET: begin
          // data is irrelevant; the write itself is the command
          nxt_ctrl = CTRL_DEFAULT;
        end
        IDX_BIAS: begin
          // reserved codes have bit 0 set; such writes leave the level alone
          if (!hwdata[BIAS_SEL_LSB]) begin
            nxt_ctrl.bias_level_select = hwdata[BIAS_SEL_LSB+:2];
          end
          nxt_ctrl.bias_generator_on = hwdata[BIAS_ON_BIT];
        end
        IDX_MIDRAIL: begin
          nxt_ctrl.midrail_buffer_on = hwdata[MID_BUF_BIT];
          nxt_ctrl.midrail_divider_select = hwdata[MID_DIV_LSB+:2];
          nxt_ctrl.midrail_output_on = hwdata[MID_ON_BIT];
        end
        IDX_MIC: begin
          nxt_ctrl.mic_current_threshold = hwdata[MIC_THR_LSB+:3];
          nxt_ctrl.mic_short_threshold = hwdata[MIC_SHORT_LSB+:2];
          nxt_ctrl.mic_detect_on = hwdata[MIC_DET_BIT];
          nxt_ctrl.mic_supply_on = hwdata[MIC_ON_BIT];
        end
        default: begin
          nxt_ctrl = ctrl_ff;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_DEFAULT;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign ctrl = ctrl_ff;

  // read view built from next-state values; only field bits are placed
  always_comb begin
    rd_data = 32'h0;
    case (rd_idx)
      IDX_RESET: begin
        rd_data[REG_W-1:0] = DEV_ID;
      end
      IDX_BIAS: begin
        rd_data[BIAS_SEL_LSB+:2] = nxt_ctrl.bias_level_select;
        rd_data[BIAS_ON_BIT] = nxt_ctrl.bias_generator_on;
      end
      IDX_MIDRAIL: begin
        rd_data[MID_BUF_BIT] = nxt_ctrl.midrail_buffer_on;
        rd_data[MID_DIV_LSB+:2] = nxt_ctrl.midrail_divider_select;
        rd_data[MID_ON_BIT] = nxt_ctrl.midrail_output_on;
      end
      IDX_MIC: begin
        rd_data[MIC_THR_LSB+:3] = nxt_ctrl.mic_current_threshold;
        rd_data[MIC_SHORT_LSB+:2] = nxt_ctrl.mic_short_threshold;
        rd_data[MIC_DET_BIT] = nxt_ctrl.mic_detect_on;
        rd_data[MIC_ON_BIT] = nxt_ctrl.mic_supply_on;
      end
      default: begin
        rd_data = 32'h0;
      end
    endcase
  end

  // checks

  logic seen_edge_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_edge_ff <= 1'h0;
    end else begin
      seen_edge_ff <= 1'h1;
    end
  end

  sequence s_addr(logic w, logic [31:0] a);
    hsel && htrans == HTRANS_NONSEQ && hready && hwrite == w &&
    haddr == a && hsize == HSIZE_WORD;
  endsequence

  sequence s_wr_data(logic [IDX_W-1:0] i);
    wr.en && wr.idx == i;
  endsequence

  property p_soft_reset;
    @(posedge hclk) disable iff (!hresetn)
    s_addr(1'h1, ADDR_RESET) ##1 s_wr_data(IDX_RESET)
    |=> ctrl == CTRL_DEFAULT;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset write did not restore defaults");

  property p_ident_read;
    @(posedge hclk) disable iff (!hresetn)
    s_addr(1'h0, ADDR_RESET) |=> hrdata == {16'h0, DEV_ID};
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("ident read returned wrong value");

  property p_reset_default;
    @(posedge hclk) disable iff (!hresetn)
    !seen_edge_ff |-> ctrl == CTRL_DEFAULT;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("control not at default after reset");

  property p_bias_sel_write;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_BIAS) |=>
      (($past(hwdata[BIAS_SEL_LSB]) == 1'h0) ?
        ctrl.bias_level_select == $past(hwdata[BIAS_SEL_LSB+1-:2]) :
        $stable(ctrl.bias_level_select));
  endproperty
  a_bias_sel_write: assert property (p_bias_sel_write)
    else $error("bias level select mishandled");

  property p_bias_sel_legal;
    @(posedge hclk) disable iff (!hresetn)
    ctrl.bias_level_select == BIAS_LOW_POWER ||
    ctrl.bias_level_select == BIAS_HIGH_PERF;
  endproperty
  a_bias_sel_legal: assert property (p_bias_sel_legal)
    else $error("bias level select holds reserved code");

  property p_bias_on;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_BIAS) |=>
      ctrl.bias_generator_on == $past(hwdata[BIAS_ON_BIT]);
  endproperty
  a_bias_on: assert property (p_bias_on)
    else $error("bias generator enable not written");

  property p_mid_buf;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_MIDRAIL) |=>
      ctrl.midrail_buffer_on == $past(hwdata[MID_BUF_BIT]);
  endproperty
  a_mid_buf: assert property (p_mid_buf)
    else $error("midrail buffer enable not written");

  property p_mid_div;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_MIDRAIL) |=>
      ctrl.midrail_divider_select == $past(hwdata[MID_DIV_LSB+1-:2]);
  endproperty
  a_mid_div: assert property (p_mid_div)
    else $error("midrail divider select not written");

  property p_mic_thr;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_MIC) |=>
      ctrl.mic_current_threshold == $past(hwdata[MIC_THR_LSB+2-:3]) &&
      ctrl.mic_short_threshold == $past(hwdata[MIC_SHORT_LSB+1-:2]);
  endproperty
  a_mic_thr: assert property (p_mic_thr)
    else $error("mic thresholds not written");

  property p_mic_enables;
    @(posedge hclk) disable iff (!hresetn)
    s_wr_data(IDX_MIC) |=>
      ctrl.mic_detect_on == $past(hwdata[MIC_DET_BIT]) &&
      ctrl.mic_supply_on == $past(hwdata[MIC_ON_BIT]);
  endproperty
  a_mic_enables: assert property (p_mic_enables)
    else $error("mic enables not written");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    !wr.en |=> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold)
    else $error("control changed without a write");

  property p_unused_zero;
    @(posedge hclk) disable iff (!hresetn)
    s_addr(1'h0, ADDR_BIAS) or s_addr(1'h0, ADDR_MIDRAIL) or
    s_addr(1'h0, ADDR_MIC)
    |=> hrdata[31:7] == 25'h0 && !($past(haddr) == ADDR_BIAS && hrdata[1]) &&
        ($past(haddr) != ADDR_BIAS || hrdata[6:4] == 3'h0) &&
        ($past(haddr) != ADDR_MIDRAIL || hrdata[5:3] == 3'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unoccupied bits read nonzero");

  property p_readback;
    @(posedge hclk) disable iff (!hresetn)
    s_addr(1'h0, ADDR_MIC) ##1 (htrans == HTRANS_IDLE)
    |-> hrdata[6:0] == {ctrl.mic_current_threshold,
        ctrl.mic_short_threshold, ctrl.mic_detect_on, ctrl.mic_supply_on};
  endproperty
  a_readback: assert property (p_readback)
    else $error("mic register readback mismatch");

  property p_unmapped_write;
    @(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && hwrite && !cbr_is_mapped(haddr[7:2])
    |=> !wr.en;
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write produced a strobe");

  sequence s_rd_done(logic [31:0] a);
    s_addr(1'h0, a) ##1 (htrans == HTRANS_IDLE);
  endsequence

  property p_bias_readback;
    @(posedge hclk) disable iff (!hresetn)
    s_rd_done(ADDR_BIAS) |->
      hrdata[3:0] == {ctrl.bias_level_select, 1'h0, ctrl.bias_generator_on};
  endproperty
  a_bias_readback: assert property (p_bias_readback)
    else $error("bias register readback mismatch");

  property p_mid_readback;
    @(posedge hclk) disable iff (!hresetn)
    s_rd_done(ADDR_MIDRAIL) |->
      hrdata[6:0] == {ctrl.midrail_buffer_on, 3'h0,
        ctrl.midrail_divider_select, ctrl.midrail_output_on};
  endproperty
  a_mid_readback: assert property (p_mid_readback)
    else $error("midrail register readback mismatch");

  // refused reads still answer OKAY, so zero data is the only visible trace
  property p_refused_read;
    @(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && !hwrite &&
    (haddr[31:8] != 24'h0 || haddr[1:0] != 2'h0 || hsize != HSIZE_WORD ||
     !cbr_is_mapped(haddr[7:2]))
    |=> hrdata == 32'h0;
  endproperty
  a_refused_read: assert property (p_refused_read)
    else $error("refused read returned nonzero data");

  property p_sub_word_write;
    @(posedge hclk) disable iff (!hresetn)
    hsel && htrans[1] && hready && hwrite && hsize != HSIZE_WORD |=> !wr.en;
  endproperty
  a_sub_word_write: assert property (p_sub_word_write)
    else $error("sub-word write produced a strobe");

endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cbr_pkg::*;

  // arbitrary identification value, not any real part's code
  localparam logic [15:0] ID = 16'h5A3C;

  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  cbr_ctrl_type ctrl;
  logic [15:0] eb, em, ec;
  logic [31:0] rdv;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #25 hclk = ~hclk;

  // hready loops back from the only slave
  cbr_regs #(.DEV_ID(ID)) i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .ctrl(ctrl)
  );

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // entered just after a rising edge; single transfer of size sz, waits on hready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= HTRANS_IDLE;
    hsel <= 1'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    chk("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
  endtask

  // compares the ident word against ID, and the other registers and the control outputs against the shadow copy
  task automatic check_all();
    logic [31:0] rd;
    cbr_ctrl_type e;
    @(negedge hclk);
    e = {eb[3:2], eb[0], em[6], em[2:1], em[0], ec[6:4], ec[3:2], ec[1], ec[0]};
    chk("ctrl", {18'h0, e}, {18'h0, ctrl});
    @(posedge hclk);
    xfer(ADDR_RESET, 1'h0, 32'h0, HSIZE_WORD, rd);
    chk("ident", {16'h0, ID}, rd);
    xfer(ADDR_BIAS, 1'h0, 32'h0, HSIZE_WORD, rd);
    chk("bias", {16'h0, eb}, rd);
    xfer(ADDR_MIDRAIL, 1'h0, 32'h0, HSIZE_WORD, rd);
    chk("midrail", {16'h0, em}, rd);
    xfer(ADDR_MIC, 1'h0, 32'h0, HSIZE_WORD, rd);
    chk("mic", {16'h0, ec}, rd);
  endtask

  task automatic set_defaults();
    eb = 16'h0008;
    em = 16'h0000;
    ec = 16'h0000;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    xfer(a, 1'h1, d, HSIZE_WORD, rd);
    case (a)
      ADDR_RESET: begin
        set_defaults();
      end
      ADDR_BIAS: begin
        eb[0] = d[0];
        // reserved codes 01 and 11 leave the level untouched
        if (d[2] == 1'h0) begin
          eb[3:2] = d[3:2];
        end
      end
      ADDR_MIDRAIL: begin
        em = d[15:0] & 16'h0047;
      end
      ADDR_MIC: begin
        ec = d[15:0] & 16'h007F;
      end
      default: begin
      end
    endcase
    check_all();
  endtask

  initial begin
    set_defaults();
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    check_all();
    wr(ADDR_BIAS, 32'h0000_0001);
    wr(ADDR_BIAS, 32'hFFFF_FFF4);
    wr(ADDR_BIAS, 32'h0000_000D);
    wr(ADDR_BIAS, 32'h0000_0008);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_MIDRAIL, {25'h0, i[1], 3'h0, i[1:0], i[0]});
    end
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_MIC, {25'h0, i[2:0], i[1:0], i[0], i[1]});
    end
    wr(ADDR_MIDRAIL, 32'hFFFF_FFFF);
    wr(ADDR_MIC, 32'hFFFF_FFFF);
    wr(ADDR_BIAS, 32'h0000_0001);
    // unmapped, aliased and sub-word writes must change nothing
    wr(32'h0000_0008, 32'hFFFF_FFFF);
    wr(32'h0000_1010, 32'h0000_0000);
    xfer(ADDR_MIC, 1'h1, 32'h0000_0000, 3'h1, rdv);
    check_all();
    xfer(32'h0000_0004, 1'h0, 32'h0, HSIZE_WORD, rdv);
    chk("unmapped", 32'h0, rdv);
    xfer(ADDR_MIC, 1'h0, 32'h0, 3'h1, rdv);
    chk("sub-word read", 32'h0, rdv);
    xfer(32'h0000_1010, 1'h0, 32'h0, HSIZE_WORD, rdv);
    chk("aliased read", 32'h0, rdv);
    xfer(ADDR_MIC + 32'h2, 1'h0, 32'h0, HSIZE_WORD, rdv);
    chk("unaligned read", 32'h0, rdv);
    wr(ADDR_RESET, 32'h0000_0000);
    wr(ADDR_MIC, 32'h0000_0055);
    wr(ADDR_MIDRAIL, 32'h0000_0043);
    wr(ADDR_RESET, 32'hFFFF_FFFF);
    wr(ADDR_BIAS, 32'h0000_0001);
    // asynchronous reset in mid-run, lowered right after an edge
    @(posedge hclk);
    hresetn <= 1'h0;
    @(negedge hclk);
    chk("ctrl in reset", {18'h0, CTRL_DEFAULT}, {18'h0, ctrl});
    chk("hrdata in reset", 32'h0, hrdata);
    set_defaults();
    @(posedge hclk);
    hresetn <= 1'h1;
    check_all();
    give_verdict();
  end
endmodule
`default_nettype wire
